// ### design/pdc_pkg.sv
package pdc_pkg;
   // register map
   localparam logic [7:0] PDC_CTRL_OFFSET   = 8'h10;
   localparam logic [7:0] PDC_STATUS_OFFSET = 8'h14;
   localparam logic [31:0] PDC_CTRL_RESET   = 32'h0000_0000;
   // control field positions
   localparam int PDC_CPU_CLK_BIT  = 0;
   localparam int PDC_FAB_CLK_BIT  = 1;
   localparam int PDC_OSC_BIT      = 2;
   localparam int PDC_PIN_BIT      = 3;
   localparam int PDC_REQ_BIT      = 4;
   localparam int PDC_POWER_ON_RESET_DISABLE  = 5;
   localparam int PDC_CTRL_WIDTH   = 6;
   // status field positions
   localparam int PDC_ST_ACTIVE_BIT = 0;
   localparam int PDC_ST_WAKE_BIT   = 1;
   localparam int PDC_ST_APPLICATION_RESET_SIDEBAND_BIT = 2;
   // interrupt sources: three fabric lines plus the system interrupt
   localparam int PDC_IRQ_LINES = 4;
endpackage : pdc_pkg

// ### design/pdc_ctrl_if.sv
`timescale 1ns/1ns
// control fields passed from the register file to the gating logic
interface pdc_ctrl_if;
   logic req;
   logic por_dis;
   logic pin_sel;
   logic osc_sel;
   logic fab_sel;
   logic cpu_sel;
   logic wake;
   modport regs (output req, output por_dis, output pin_sel, output osc_sel,
                 output fab_sel, output cpu_sel, input wake);
   modport gate (input req, input por_dis, input pin_sel, input osc_sel,
                 input fab_sel, input cpu_sel, output wake);
endinterface : pdc_ctrl_if

// ### design/pdc_gate.sv
`timescale 1ns/1ns
// combines request and selects into shutdown levels; no sequencing
module pdc_gate
   import pdc_pkg::*;
(
   pdc_ctrl_if.gate            c,
   input  wire logic [PDC_IRQ_LINES-1:0] irq,
   output logic                stop_osc,
   output logic                stop_pins,
   output logic                stop_fab,
   output logic                stop_cpu,
   output logic                por_off
);
   // any interrupt line asks to wake
   assign c.wake    = |irq;
   // a select acts only while the request is set; clearing it re-enables all
   assign stop_osc  = c.req & c.osc_sel;
   assign stop_pins = c.req & c.pin_sel;
   assign stop_fab  = c.req & c.fab_sel;
   assign stop_cpu  = c.req & c.cpu_sel;
   assign por_off   = c.por_dis;
endmodule : pdc_gate

// ### design/pdc_top.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
// How it works
// - bit 4 of the control register requests power-down, zero keeps the device active.
// - a set request shuts the selected circuits down at once with no sequencing.
// - a select bit turns its circuit off only during power-down.
// - bit 5 disables the power-on-reset circuit.
// - bit 3 selects the design-time chosen pins for shutdown in power-down.
// - bit 2 stops the ring oscillator in power-down.
// - bit 1 blocks the bus clock to the fabric in power-down.
// - bit 0 blocks the bus clock to the processor and system bus in power-down.
// - system reset clears the whole control register.
// - any interrupt clears the request bit asynchronously without a clock.
// - clearing the request re-enables every selected circuit.
// - the application reset sideband resets the system and the control register.
// - turning off the memory subsystem issues self-refresh then powers it down.
module pdc_top
   import pdc_pkg::*;
(
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // wake and reset sources
   input  wire logic [2:0]  fabric_irq,
   input  wire logic        system_irq,
   input  wire logic        application_reset_sideband,
   // memory subsystem off request from its own control logic
   input  wire logic        sdram_off_req,
   // shutdown controls
   output logic             ring_osc_stop,
   output logic             pin_shutdown,
   output logic             fabric_clock_gate,
   output logic             cpu_clock_gate,
   output logic             por_disable,
   output logic             system_reset_n,
   output logic             sdram_self_refresh,
   output logic             sdram_power_down
);
   // wake path: interrupts act directly on the request flop, unsynchronised on purpose
   pdc_ctrl_if c ();
   logic [PDC_IRQ_LINES-1:0] irq_all;
   logic stop_osc, stop_pins, stop_fab, stop_cpu, por_off;
   assign irq_all = {system_irq, fabric_irq};

   pdc_gate u_gate (
      .c         (c),
      .irq       (irq_all),
      .stop_osc  (stop_osc),
      .stop_pins (stop_pins),
      .stop_fab  (stop_fab),
      .stop_cpu  (stop_cpu),
      .por_off   (por_off)
   );

   // reset sideband from the fabric: two-stage sync, then a held system reset
   logic app_s1_reg, app_s2_reg;
   logic application_reset_sideband_flag_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         app_s1_reg <= 1'b0;
         app_s2_reg <= 1'b0;
      end else if (clk_en) begin
         app_s1_reg <= application_reset_sideband;
         app_s2_reg <= app_s1_reg;
      end
   end

   // combined reset for the control register: pin reset or fabric reset
   logic sys_rst_n;
   assign sys_rst_n = presetn & ~app_s2_reg;

   // apb decode
   logic wr_ctrl, rd_hit, acc;
   assign acc     = psel & penable;
   assign wr_ctrl = acc & pwrite & (paddr == PDC_CTRL_OFFSET);
   assign rd_hit  = (paddr == PDC_CTRL_OFFSET) | (paddr == PDC_STATUS_OFFSET);

   // select bits: plain flops cleared by any system reset
   logic [PDC_CTRL_WIDTH-1:0] sel_reg, sel_next;
   assign sel_next = wr_ctrl ? pwdata[PDC_CTRL_WIDTH-1:0] : sel_reg;
   always_ff @(posedge pclk or negedge sys_rst_n) begin
      if (!sys_rst_n)
         sel_reg <= PDC_CTRL_RESET[PDC_CTRL_WIDTH-1:0];
      else if (clk_en)
         sel_reg <= sel_next;
   end

   // request flop: wake clears it without a clock, writes set it
   logic req_rst_n, req_reg;
   assign req_rst_n = sys_rst_n & ~c.wake;
   always_ff @(posedge pclk or negedge req_rst_n) begin
      if (!req_rst_n)
         req_reg <= 1'b0;
      else if (clk_en && wr_ctrl)
         req_reg <= pwdata[PDC_REQ_BIT];
   end

   assign c.req     = req_reg;
   assign c.por_dis = sel_reg[PDC_POWER_ON_RESET_DISABLE];
   assign c.pin_sel = sel_reg[PDC_PIN_BIT];
   assign c.osc_sel = sel_reg[PDC_OSC_BIT];
   assign c.fab_sel = sel_reg[PDC_FAB_CLK_BIT];
   assign c.cpu_sel = sel_reg[PDC_CPU_CLK_BIT];

   // wake lines synchronised for the status flag only; the request itself is
   // cleared by the raw lines because the bus clock may be stopped by then
   logic wake_s1_reg, wake_s2_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_s1_reg <= 1'b0;
         wake_s2_reg <= 1'b0;
      end else if (clk_en) begin
         wake_s1_reg <= c.wake;
         wake_s2_reg <= wake_s1_reg;
      end
   end

   // remembers that power-down was requested until the synchronised wake is seen;
   // the request flop itself is already cleared when that happens
   logic armed_reg, armed_next, wr_clear_req;
   assign wr_clear_req = wr_ctrl & ~pwdata[PDC_REQ_BIT];
   assign armed_next   = ~wr_clear_req & (req_reg | (armed_reg & ~wake_s2_reg));
   always_ff @(posedge pclk or negedge sys_rst_n) begin
      if (!sys_rst_n)
         armed_reg <= 1'b0;
      else if (clk_en)
         armed_reg <= armed_next;
   end

   // wake-seen and app-reset sticky flags, cleared by writing ones to status
   logic wake_flag_reg;
   logic wr_status;
   assign wr_status = acc & pwrite & (paddr == PDC_STATUS_OFFSET);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_flag_reg   <= 1'b0;
         application_reset_sideband_flag_reg <= 1'b0;
      end else if (clk_en) begin
         // set wins over clear
         wake_flag_reg   <= (armed_reg & wake_s2_reg) |
                            (wake_flag_reg & ~(wr_status & pwdata[PDC_ST_WAKE_BIT]));
         application_reset_sideband_flag_reg <= app_s2_reg |
                            (application_reset_sideband_flag_reg & ~(wr_status & pwdata[PDC_ST_APPLICATION_RESET_SIDEBAND_BIT]));
      end
   end

   // read mux; reserved bits are zero
   logic [31:0] rd_mux;
   assign rd_mux = (paddr == PDC_CTRL_OFFSET)
                 ? {26'h0, sel_reg[PDC_POWER_ON_RESET_DISABLE], req_reg,
                    sel_reg[PDC_PIN_BIT:PDC_CPU_CLK_BIT]}
                 : (paddr == PDC_STATUS_OFFSET)
                 ? {29'h0, application_reset_sideband_flag_reg, wake_flag_reg, req_reg}
                 : 32'h0;

   // apb answer one cycle after the setup, so every access completes without a wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~rd_hit;
         prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
      end
   end

   // memory subsystem off: self-refresh first, power-down the cycle after
   logic sr_reg;
   always_ff @(posedge pclk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         sr_reg             <= 1'b0;
         sdram_self_refresh <= 1'b0;
         sdram_power_down   <= 1'b0;
      end else if (clk_en) begin
         sr_reg             <= sdram_off_req;
         sdram_self_refresh <= sdram_off_req & ~sr_reg;
         sdram_power_down   <= sdram_off_req & sr_reg;
      end
   end

   // a write decides the new levels itself, so clearing the request releases
   // every circuit at that same edge instead of one cycle later
   logic [3:0] stop_now, stop_next;
   assign stop_now  = {stop_pins, stop_osc, stop_fab, stop_cpu};
   assign stop_next = wr_ctrl
                    ? ({4{pwdata[PDC_REQ_BIT]}} & pwdata[PDC_PIN_BIT:PDC_CPU_CLK_BIT])
                    : stop_now;

   // shutdown outputs: registered, but cleared with the request flop so a wake
   // releases them at once even though the bus clock itself may be stopped
   always_ff @(posedge pclk or negedge req_rst_n) begin
      if (!req_rst_n) begin
         ring_osc_stop     <= 1'b0;
         pin_shutdown      <= 1'b0;
         fabric_clock_gate <= 1'b0;
         cpu_clock_gate    <= 1'b0;
      end else if (clk_en) begin
         ring_osc_stop     <= stop_next[PDC_OSC_BIT];
         pin_shutdown      <= stop_next[PDC_PIN_BIT];
         fabric_clock_gate <= stop_next[PDC_FAB_CLK_BIT];
         cpu_clock_gate    <= stop_next[PDC_CPU_CLK_BIT];
      end
   end

   // por disable and system reset outputs
   always_ff @(posedge pclk or negedge sys_rst_n) begin
      if (!sys_rst_n)
         por_disable <= 1'b0;
      else if (clk_en)
         por_disable <= wr_ctrl ? pwdata[PDC_POWER_ON_RESET_DISABLE] : por_off;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         system_reset_n <= 1'b0;
      else if (clk_en)
         system_reset_n <= ~app_s2_reg;
   end

   // assertions
   a_req_write_sets: assert property (@(posedge pclk) disable iff (!sys_rst_n)
      clk_en && wr_ctrl && pwdata[PDC_REQ_BIT] && !c.wake ##1 !c.wake |-> req_reg)
      else $error("request not set by write");
   a_osc_follows: assert property (@(posedge pclk) disable iff (!req_rst_n)
      clk_en && stop_osc && !wr_ctrl |=> ring_osc_stop)
      else $error("ring oscillator not stopped");
   a_pin_gated: assert property (@(posedge pclk) disable iff (!presetn)
      pin_shutdown |-> $past(req_reg) || $past(wr_ctrl))
      else $error("pins shut without request");
   a_fab_follows: assert property (@(posedge pclk) disable iff (!req_rst_n)
      clk_en && stop_fab && !wr_ctrl |=> fabric_clock_gate)
      else $error("fabric clock not gated");
   a_cpu_follows: assert property (@(posedge pclk) disable iff (!req_rst_n)
      clk_en && stop_cpu && !wr_ctrl |=> cpu_clock_gate)
      else $error("cpu clock not gated");
   a_wake_clears: assert property (@(posedge pclk) disable iff (!presetn)
      c.wake |-> !req_reg && !cpu_clock_gate)
      else $error("wake did not clear request");
   a_application_reset_sideband_clears: assert property (@(posedge pclk) disable iff (!presetn)
      app_s2_reg |-> sel_reg == '0 && !req_reg)
      else $error("fabric reset left control set");
   a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      paddr == PDC_CTRL_OFFSET |-> rd_mux[31:PDC_CTRL_WIDTH] == '0)
      else $error("reserved bits not zero");
   a_por_follows: assert property (@(posedge pclk) disable iff (!sys_rst_n)
      clk_en && !wr_ctrl ##1 clk_en |-> por_disable == $past(c.por_dis))
      else $error("por disable wrong");
   a_sr_first: assert property (@(posedge pclk) disable iff (!sys_rst_n)
      clk_en && sdram_off_req && !sr_reg ##1 clk_en && sdram_off_req
      |-> sdram_self_refresh ##1 sdram_power_down)
      else $error("self refresh not issued first");
   a_clear_releases: assert property (@(posedge pclk) disable iff (!sys_rst_n)
      clk_en && wr_ctrl && !pwdata[PDC_REQ_BIT]
      |=> !ring_osc_stop && !pin_shutdown && !fabric_clock_gate && !cpu_clock_gate)
      else $error("clearing the request left a circuit off");
   a_wake_flagged: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && armed_reg && wake_s2_reg |=> wake_flag_reg)
      else $error("wake from power-down not flagged");
endmodule : pdc_top

// ### testbench/pdc_top_tb.sv
`timescale 1ns/1ns
// self-checking bench: apb register traffic, wake lines and resets driven directly
module pdc_top_tb
   import pdc_pkg::*;
;
   logic        pclk, presetn, clk_en, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_data;
   logic        pready, pslverr, rd_err, system_irq, application_reset_sideband;
   logic [2:0]  fabric_irq;
   logic        sdram_off_req, ring_osc_stop, pin_shutdown, fabric_clock_gate;
   logic        cpu_clock_gate, por_disable, system_reset_n;
   logic        sdram_self_refresh, sdram_power_down;
   int          fail_count, n_checks, n;
   // shutdown levels gathered in control-register bit order
   wire  [3:0]  stops = {pin_shutdown, ring_osc_stop, fabric_clock_gate, cpu_clock_gate};

   pdc_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .fabric_irq(fabric_irq),
      .system_irq(system_irq), .application_reset_sideband(application_reset_sideband),
      .sdram_off_req(sdram_off_req), .ring_osc_stop(ring_osc_stop),
      .pin_shutdown(pin_shutdown), .fabric_clock_gate(fabric_clock_gate),
      .cpu_clock_gate(cpu_clock_gate), .por_disable(por_disable),
      .system_reset_n(system_reset_n), .sdram_self_refresh(sdram_self_refresh),
      .sdram_power_down(sdram_power_down));

   // 100 mhz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one apb transfer; request held until pready is sampled high, bounded wait
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) fail_count++;
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb

   // waits at falling edges for a level, giving up after a bounded count;
   // pick 0 watches system_reset_n, pick 1 watches sdram_self_refresh
   task automatic wait_lvl(input int pick, input logic v);
      logic s;
      n = 0;
      s = (pick != 0) ? sdram_self_refresh : system_reset_n;
      while (s !== v && n < 10) begin
         @(negedge pclk);
         n++;
         s = (pick != 0) ? sdram_self_refresh : system_reset_n;
      end
      chk(s, v);
   endtask : wait_lvl

   // watchdog: the whole sequence needs well under 2000 cycles
   initial begin
      repeat (5000) @(posedge pclk);
      fail_count++;
      conclude();
   end

   initial begin
      {presetn, psel, penable, pwrite, system_irq, application_reset_sideband} = '0;
      {paddr, pwdata, fabric_irq, sdram_off_req} = '0;
      clk_en = 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, PDC_CTRL_OFFSET, 32'h0);
      chk(rd_data, PDC_CTRL_RESET);
      // selects alone, reserved bits written high
      apb(1'b1, PDC_CTRL_OFFSET, 32'hffff_ffef);
      chk({stops, por_disable}, 5'h01);
      apb(1'b0, PDC_CTRL_OFFSET, 32'h0);
      chk(rd_data, 32'h0000_002f);
      // each select with the request, then request cleared
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, PDC_CTRL_OFFSET, 32'h10 | (32'h1 << i));
         chk(stops, 4'h1 << i);
         apb(1'b1, PDC_CTRL_OFFSET, 32'h0000_000f);
         chk(stops, 4'h0);
      end
      // every wake line clears the request with the clock frozen
      for (int j = 0; j < 4; j++) begin
         // stands for software that has finished its memory and clock preparation
         apb(1'b1, PDC_CTRL_OFFSET, 32'h0000_001f);
         @(posedge pclk);
         clk_en <= 1'b0;
         {system_irq, fabric_irq} <= 4'h1 << j;
         #1;
         chk(stops, 4'h0);
         // line held a few enabled cycles so the status flag can sample it
         @(posedge pclk);
         clk_en <= 1'b1;
         repeat (3) @(posedge pclk);
         {system_irq, fabric_irq} <= 4'h0;
         apb(1'b0, PDC_CTRL_OFFSET, 32'h0);
         chk(rd_data, 32'h0000_000f);
      end
      apb(1'b0, PDC_STATUS_OFFSET, 32'h0);
      chk(rd_data, 32'h0000_0002);
      // unmapped address refused
      apb(1'b1, 8'h20, 32'hffff_ffff);
      chk(rd_err, 1'b1);
      apb(1'b0, 8'h20, 32'h0);
      chk({rd_err, rd_data}, {1'b1, 32'h0});
      // fabric reset out of power-down
      apb(1'b1, PDC_CTRL_OFFSET, 32'h0000_003f);
      @(posedge pclk);
      application_reset_sideband <= 1'b1;
      wait_lvl(0, 1'b0);
      @(posedge pclk);
      application_reset_sideband <= 1'b0;
      wait_lvl(0, 1'b1);
      apb(1'b0, PDC_CTRL_OFFSET, 32'h0);
      chk({rd_data, stops, por_disable}, 37'h0);
      apb(1'b0, PDC_STATUS_OFFSET, 32'h0);
      chk(rd_data, 32'h0000_0006);
      // memory subsystem off: self-refresh pulse, then power-down level
      @(posedge pclk);
      sdram_off_req <= 1'b1;
      wait_lvl(1, 1'b1);
      @(negedge pclk);
      chk({sdram_self_refresh, sdram_power_down}, 2'b01);
      @(posedge pclk);
      sdram_off_req <= 1'b0;
      // system reset in mid-run
      apb(1'b1, PDC_CTRL_OFFSET, 32'h0000_003f);
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, PDC_CTRL_OFFSET, 32'h0);
      chk({rd_data, stops}, 36'h0);
      conclude();
   end
endmodule : pdc_top_tb
